/* File: hdl/sru_top.sv */
// apb-attached shift and rotate unit of a 20-bit extended core
// assumes an apb master on pclk; one operation in flight at a time
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sru_top
    import sru_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRU_ADDR_W-1:0] paddr,
    input wire logic [SRU_DATA_W-1:0] pwdata,
    output logic [SRU_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    // two states: the shift itself is one combinational cycle
    typedef enum logic [0:0] {
        sru_idle = 1'b0,   // waiting for a start
        sru_exec = 1'b1    // operands latched, result this cycle
    } sru_fsm_type;

    // every flip-flop of the unit lives in this one struct
    typedef struct packed {
        sru_fsm_type fsm;             // execution state
        logic pready;                 // apb completion
        logic pslverr;                // apb error answer
        logic [SRU_DATA_W-1:0] prdata; // apb read data
        sru_op_type op;               // selected operation
        sru_size_type size;           // selected operand size
        logic [2:0] count;            // positions for multi forms
        logic mem_dest;               // destination is memory
        logic [SRU_W-1:0] operand;    // destination operand value
        logic [SRU_W-1:0] result;     // last result
        logic [2:0] lanes;            // byte lanes to write back
        logic flag_c;                 // carry
        logic flag_z;                 // zero
        logic flag_n;                 // negative
        logic flag_v;                 // overflow
        logic irq_en;                 // global_irq_enable_bit
        logic core_off;               // core_off_bit
        logic osc_off;                // oscillator_off_bit
        logic err;                    // last start refused
    } sru_state_type;

    sru_state_type cur;   // registered state
    sru_state_type nxt;   // next state

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    logic [SRU_W-1:0] width_mask;    // selected width mask
    logic [SRU_W-1:0] msb_bit;       // one-hot sign position
    logic [2:0] lane_set;            // lanes covered by the size
    logic is_multi;                  // register-only multi form
    logic is_left;                   // left shift family
    logic use_carry;                 // rotate through carry
    logic use_sign;                  // arithmetic right
    logic single_left;               // single left, overflow defined
    logic [2:0] eff_count;           // steps actually taken
    logic [SRU_W-1:0] core_result;   // shifter result
    logic core_carry;                // shifter carry
    logic gen_n;                     // negative flag
    logic gen_z;                     // zero flag
    logic gen_v;                     // overflow flag

    // size selects width, sign position and lanes
    // size 3 never starts, so the last branch is the 20-bit form
    always_comb begin
        if (cur.size == sru_size_byte) begin
            width_mask = SRU_MASK_BYTE;
            msb_bit = SRU_MSB_BYTE;
            lane_set = SRU_LANES_BYTE;
        end else if (cur.size == sru_size_word) begin
            width_mask = SRU_MASK_WORD;
            msb_bit = SRU_MSB_WORD;
            lane_set = SRU_LANES_WORD;
        end else begin
            width_mask = SRU_MASK_ADDR;
            msb_bit = SRU_MSB_ADDR;
            lane_set = SRU_LANES_ADDR;
        end
    end

    // operation selects direction, fill and step count
    always_comb begin
        is_multi = (cur.op == reg_shift_left_multi) ||
                   (cur.op == reg_shift_right_arith_multi) ||
                   (cur.op == reg_rotate_right_carry_multi);
        is_left = (cur.op == reg_shift_left_multi) ||
                  (cur.op == ext_shift_left_arith) ||
                  (cur.op == ext_rotate_left_carry);
        use_carry = (cur.op == ext_rotate_left_carry) ||
                    (cur.op == reg_rotate_right_carry_multi) ||
                    (cur.op == ext_rotate_right_carry);
        use_sign = (cur.op == reg_shift_right_arith_multi) ||
                   (cur.op == ext_shift_right_arith);
        // multi-left overflow is undefined; it is driven low
        single_left = (cur.op == ext_shift_left_arith) ||
                      (cur.op == ext_rotate_left_carry);
        // single forms ignore the count field: one position always
        // multi forms take the count from the base request alone
        if (is_multi) begin
            eff_count = cur.count;
        end else begin
            eff_count = SRU_CNT_MIN;
        end
    end

    // ------------------------------------------------------------
    // datapath instances
    // ------------------------------------------------------------
    // operand masked first so bits above the size never leak in
    sru_shift_core #(
        .W(SRU_W),
        .MAX_STEPS(SRU_CNT_MAX)
    ) u_shift (
        .operand(cur.operand & width_mask),
        .width_mask(width_mask),
        .msb_bit(msb_bit),
        .shift_left(is_left),
        .fill_carry(use_carry),
        .fill_sign(use_sign),
        .count(eff_count),
        .carry_in(cur.flag_c),
        .result(core_result),
        .carry_out(core_carry)
    );

    // flags see the same masked operand for the overflow window
    sru_flag_gen #(
        .W(SRU_W)
    ) u_flags (
        .operand(cur.operand & width_mask),
        .result(core_result),
        .msb_bit(msb_bit),
        .single_left(single_left),
        .flag_n(gen_n),
        .flag_z(gen_z),
        .flag_v(gen_v)
    );

    // ------------------------------------------------------------
    // register read image
    // ------------------------------------------------------------
    logic [SRU_DATA_W-1:0] ctrl_image;    // control readback
    logic [SRU_DATA_W-1:0] status_image;  // status readback
    logic [SRU_DATA_W-1:0] read_word;     // addressed word
    logic read_hit;                       // address is mapped

    // assemble control and status words
    always_comb begin
        ctrl_image = SRU_READ_ZERO;
        ctrl_image[SRU_CTRL_OP_LSB +: 3] = cur.op;
        ctrl_image[SRU_CTRL_SIZE_LSB +: 2] = cur.size;
        ctrl_image[SRU_CTRL_CNT_LSB +: 3] = cur.count;
        ctrl_image[SRU_CTRL_MEM_BIT] = cur.mem_dest;
        status_image = SRU_READ_ZERO;
        status_image[SRU_SR_C_BIT] = cur.flag_c;
        status_image[SRU_SR_Z_BIT] = cur.flag_z;
        status_image[SRU_SR_N_BIT] = cur.flag_n;
        status_image[SRU_SR_IRQEN_BIT] = cur.irq_en;
        status_image[SRU_SR_COREOFF_BIT] = cur.core_off;
        status_image[SRU_SR_OSCSTOP_BIT] = cur.osc_off;
        status_image[SRU_SR_V_BIT] = cur.flag_v;
        status_image[SRU_ST_BUSY_BIT] = (cur.fsm == sru_exec);
        status_image[SRU_ST_ERR_BIT] = cur.err;
    end

    // address decode for reads; unmapped reads return zero
    // reads are captured in the first access cycle, so a result is
    // visible to any read set up after the execute cycle
    always_comb begin
        read_hit = 1'b1;
        if (paddr == SRU_OFF_CTRL) begin
            read_word = ctrl_image;
        end else if (paddr == SRU_OFF_OPERAND) begin
            read_word = {12'h000, cur.operand};
        end else if (paddr == SRU_OFF_RESULT) begin
            read_word = {12'h000, cur.result};
        end else if (paddr == SRU_OFF_STATUS) begin
            read_word = status_image;
        end else if (paddr == SRU_OFF_MEMMASK) begin
            read_word = {29'h00000000, cur.lanes};
        end else begin
            read_word = SRU_READ_ZERO;
            read_hit = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic access;      // apb access phase, not yet answered
    logic commit;      // apb write completing at this edge
    logic start_ok;    // start request is a legal combination
    logic [2:0] w_cnt; // count field of the write
    logic w_multi;     // write selects a multi form

    // legality of a start: multi forms are register-only, word or
    // address size, count 1..4; single forms take any size
    // a refused start still latches the fields for readback
    always_comb begin
        w_cnt = pwdata[SRU_CTRL_CNT_LSB +: 3];
        w_multi = (pwdata[SRU_CTRL_OP_LSB +: 3] == reg_shift_left_multi) ||
                  (pwdata[SRU_CTRL_OP_LSB +: 3] == reg_shift_right_arith_multi) ||
                  (pwdata[SRU_CTRL_OP_LSB +: 3] == reg_rotate_right_carry_multi);
        start_ok = (pwdata[SRU_CTRL_OP_LSB +: 3] <= ext_rotate_right_carry) &&
                   (pwdata[SRU_CTRL_SIZE_LSB +: 2] <= sru_size_addr);
        if (w_multi) begin
            start_ok = start_ok && !pwdata[SRU_CTRL_MEM_BIT] &&
                       (pwdata[SRU_CTRL_SIZE_LSB +: 2] != sru_size_byte) &&
                       (w_cnt >= SRU_CNT_MIN) && (w_cnt <= SRU_CNT_MAX);
        end
    end

    // one wait state: pready rises in the second access cycle
    always_comb begin
        access = psel && penable && !cur.pready;
        commit = psel && penable && cur.pready && pwrite;
        nxt = cur;
        nxt.pready = access;
        nxt.pslverr = 1'b0;
        // trade-off: result lands one cycle after the start, which
        // keeps the shifter off the apb read path
        // execute the latched operation; mode bits are left alone
        if (cur.fsm == sru_exec) begin
            nxt.result = core_result;
            nxt.flag_c = core_carry;
            nxt.flag_n = gen_n;
            nxt.flag_z = gen_z;
            nxt.flag_v = gen_v;
            // memory forms write back only the lanes of the size
            if (cur.mem_dest) begin
                nxt.lanes = lane_set;
            end else begin
                nxt.lanes = 3'h0;
            end
            nxt.fsm = sru_idle;
        end
        if (access) begin
            // unmapped reads and writes answer pslverr, change nothing
            if (!read_hit) begin
                nxt.pslverr = 1'b1;
            end
            if (!pwrite) begin
                nxt.prdata = read_word;
            end
        end
        // writes land at the edge that completes the transfer
        if (commit) begin
            if (paddr == SRU_OFF_CTRL) begin
                // fields latch always; a start launches only if legal
                nxt.op = sru_op_type'(pwdata[SRU_CTRL_OP_LSB +: 3]);
                nxt.size = sru_size_type'(pwdata[SRU_CTRL_SIZE_LSB +: 2]);
                nxt.count = w_cnt;
                nxt.mem_dest = pwdata[SRU_CTRL_MEM_BIT];
                if (pwdata[SRU_CTRL_GO_BIT]) begin
                    nxt.err = !start_ok;
                    if (start_ok) begin
                        nxt.fsm = sru_exec;
                    end
                end
            end else if (paddr == SRU_OFF_OPERAND) begin
                nxt.operand = pwdata[SRU_W-1:0];
            end else if (paddr == SRU_OFF_STATUS) begin
                // software loads the status image, e.g. carry before rotate
                if (cur.fsm != sru_exec) begin
                    nxt.flag_c = pwdata[SRU_SR_C_BIT];
                    nxt.flag_z = pwdata[SRU_SR_Z_BIT];
                    nxt.flag_n = pwdata[SRU_SR_N_BIT];
                    nxt.flag_v = pwdata[SRU_SR_V_BIT];
                end
                // mode bits change only here, never by an operation
                nxt.irq_en = pwdata[SRU_SR_IRQEN_BIT];
                nxt.core_off = pwdata[SRU_SR_COREOFF_BIT];
                nxt.osc_off = pwdata[SRU_SR_OSCSTOP_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // async reset loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur.fsm <= sru_idle;
            cur.pready <= 1'b0;
            cur.pslverr <= 1'b0;
            cur.prdata <= SRU_READ_ZERO;
            cur.op <= reg_shift_left_multi;
            cur.size <= sru_size_word;
            cur.count <= SRU_CNT_MIN;
            cur.mem_dest <= 1'b0;
            cur.operand <= SRU_OPERAND_RST;
            cur.result <= SRU_OPERAND_RST;
            cur.lanes <= 3'h0;
            cur.flag_c <= 1'b0;
            cur.flag_z <= 1'b0;
            cur.flag_n <= 1'b0;
            cur.flag_v <= 1'b0;
            cur.irq_en <= 1'b0;
            cur.core_off <= 1'b0;
            cur.osc_off <= 1'b0;
            cur.err <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // every output is a flip-flop of the state struct
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;

endmodule

`default_nettype wire

/* File: hdl/sru_pkg.sv */
// shared constants and types of the extended shift and rotate unit
// assumes a 20-bit core datapath and a 32-bit apb register port
package sru_pkg;

    // ------------------------------------------------------------
    // datapath widths
    // ------------------------------------------------------------
    localparam int SRU_W = 20;                  // extended operand width
    localparam int SRU_ADDR_W = 8;              // apb address bits decoded
    localparam int SRU_DATA_W = 32;             // apb data width

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SRU_OFF_CTRL = 8'h00;     // operation select and start
    localparam logic [7:0] SRU_OFF_OPERAND = 8'h04;  // destination operand in
    localparam logic [7:0] SRU_OFF_RESULT = 8'h08;   // result out
    localparam logic [7:0] SRU_OFF_STATUS = 8'h0C;   // status register image
    localparam logic [7:0] SRU_OFF_MEMMASK = 8'h10;  // byte lanes of write-back

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int SRU_CTRL_OP_LSB = 0;         // 3-bit operation code
    localparam int SRU_CTRL_SIZE_LSB = 4;       // 2-bit operand size
    localparam int SRU_CTRL_CNT_LSB = 8;        // 3-bit position count
    localparam int SRU_CTRL_MEM_BIT = 12;       // destination is memory
    localparam int SRU_CTRL_GO_BIT = 31;        // write one to start

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int SRU_SR_C_BIT = 0;            // carry
    localparam int SRU_SR_Z_BIT = 1;            // zero
    localparam int SRU_SR_N_BIT = 2;            // negative
    localparam int SRU_SR_IRQEN_BIT = 3;        // global_irq_enable_bit
    localparam int SRU_SR_COREOFF_BIT = 4;      // core_off_bit
    localparam int SRU_SR_OSCSTOP_BIT = 5;      // oscillator_off_bit
    localparam int SRU_SR_V_BIT = 8;            // overflow
    localparam int SRU_ST_BUSY_BIT = 16;        // operation in flight
    localparam int SRU_ST_ERR_BIT = 17;         // last request refused

    // ------------------------------------------------------------
    // operation codes and sizes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        reg_shift_left_multi = 3'b000,
        ext_shift_left_arith = 3'b001,
        ext_rotate_left_carry = 3'b010,
        reg_shift_right_arith_multi = 3'b011,
        ext_shift_right_arith = 3'b100,
        reg_rotate_right_carry_multi = 3'b101,
        ext_rotate_right_carry = 3'b110
    } sru_op_type;

    typedef enum logic [1:0] {
        sru_size_byte = 2'b00,
        sru_size_word = 2'b01,
        sru_size_addr = 2'b10
    } sru_size_type;

    // ------------------------------------------------------------
    // masks, sign positions, lanes, counts, reset values
    // ------------------------------------------------------------
    localparam logic [19:0] SRU_MASK_BYTE = 20'h000FF;
    localparam logic [19:0] SRU_MASK_WORD = 20'h0FFFF;
    localparam logic [19:0] SRU_MASK_ADDR = 20'hFFFFF;
    localparam logic [19:0] SRU_MSB_BYTE = 20'h00080;   // bit 7
    localparam logic [19:0] SRU_MSB_WORD = 20'h08000;   // bit 15
    localparam logic [19:0] SRU_MSB_ADDR = 20'h80000;   // bit 19
    localparam logic [2:0] SRU_LANES_BYTE = 3'h1;
    localparam logic [2:0] SRU_LANES_WORD = 3'h3;
    localparam logic [2:0] SRU_LANES_ADDR = 3'h7;
    localparam logic [2:0] SRU_CNT_MIN = 3'h1;
    localparam logic [2:0] SRU_CNT_MAX = 3'h4;
    localparam logic [19:0] SRU_OPERAND_RST = 20'h00000;
    localparam logic [31:0] SRU_READ_ZERO = 32'h00000000;

endpackage

/* File: hdl/sru_shift_core.sv */
// position-by-position shifter of the shift and rotate unit
// assumes operand already limited to the selected width
`timescale 1ns/1ps
`default_nettype none

module sru_shift_core
    import sru_pkg::*;
#(
    parameter int W = SRU_W,
    parameter int MAX_STEPS = 4
) (
    input wire logic [W-1:0] operand,
    input wire logic [W-1:0] width_mask,
    input wire logic [W-1:0] msb_bit,
    input wire logic shift_left,
    input wire logic fill_carry,
    input wire logic fill_sign,
    input wire logic [2:0] count,
    input wire logic carry_in,
    output logic [W-1:0] result,
    output logic carry_out
);

    // ------------------------------------------------------------
    // repeated single steps
    // ------------------------------------------------------------
    // one-bit steps chained rather than a barrel shift: the carry ring
    // of the rotate forms is then exact for every count
    always_comb begin
        logic [W-1:0] v;
        logic c;
        logic old_msb;
        v = operand;
        c = carry_in;
        old_msb = 1'b0;
        for (int i = 1; i <= MAX_STEPS; i++) begin
            if (i <= int'(count)) begin
                if (shift_left) begin
                    // msb leaves into carry, lsb takes zero or carry
                    old_msb = |(v & msb_bit);
                    v = (v << 1) & width_mask;
                    if (fill_carry) begin
                        v[0] = c;
                    end
                    c = old_msb;
                end else begin
                    // lsb leaves into carry, msb takes sign or carry
                    old_msb = |(v & msb_bit);
                    c = v[0];
                    v = v >> 1;
                    if (fill_sign && old_msb) begin
                        v = v | msb_bit;
                    end else if (fill_carry && (i == 1 ? carry_in : operand[i-2])) begin
                        v = v | msb_bit;
                    end
                end
            end
        end
        result = v & width_mask;
        carry_out = c;
    end

endmodule

`default_nettype wire

/* File: hdl/sru_flag_gen.sv */
// negative, zero and overflow flags of the shift and rotate unit
// assumes result already limited to the selected width
`timescale 1ns/1ps
`default_nettype none

module sru_flag_gen
    import sru_pkg::*;
#(
    parameter int W = SRU_W
) (
    input wire logic [W-1:0] operand,
    input wire logic [W-1:0] result,
    input wire logic [W-1:0] msb_bit,
    input wire logic single_left,
    output logic flag_n,
    output logic flag_z,
    output logic flag_v
);

    // ------------------------------------------------------------
    // flag logic
    // ------------------------------------------------------------
    // the overflow window 4..c of the top nibble equals top two bits differ
    always_comb begin
        flag_n = |(result & msb_bit);
        flag_z = (result == '0);
        flag_v = single_left && ((|(operand & msb_bit)) != (|(operand & (msb_bit >> 1))));
    end

endmodule

`default_nettype wire

/* File: verification/sru_top_properties.sv */
// apb-side assertions of the shift and rotate unit
// assumes it is bound onto sru_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module sru_top_properties
    import sru_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SRU_ADDR_W-1:0] paddr,
    input wire logic [SRU_DATA_W-1:0] pwdata,
    input wire logic [SRU_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ------------------------------
    // transfer timing and read data
    // ------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_qual: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside a completion");
    a_unmapped_err: assert property (pready && paddr > SRU_OFF_MEMMASK |-> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (pready && paddr == SRU_OFF_RESULT |-> !pslverr)
        else $error("mapped address refused");
    a_err_rd_zero: assert property (pslverr && !pwrite |-> prdata == SRU_READ_ZERO)
        else $error("refused read returned data");
    a_rd_hold: assert property (!pready |-> $stable(prdata))
        else $error("read data moved between reads");
    a_lanes_legal: assert property (pready && !pwrite && paddr == SRU_OFF_MEMMASK
        |-> prdata inside {32'h0, 32'h1, 32'h3, 32'h7}) else $error("bad lane mask");
endmodule
// attach to every instance of the top module
bind sru_top sru_top_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: verification/sru_apb_master.sv */
// apb master standing in for the decoder and status side
// assumes the slave ends every transfer with pready
`timescale 1ns/1ps
`default_nettype none
module sru_apb_master (
    input wire logic pclk,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h00000000,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // one transfer; request held until pready seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no own limit: the bench timeout cuts a hang
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // stale data must not look valid
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_extended_shift_rotate_unit.sv */
// self-checking bench of the shift and rotate unit
// assumes sru_top with one wait state per apb transfer
`timescale 1ns/1ps
`default_nettype none
module tb_extended_shift_rotate_unit
    import sru_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    always #12.5 pclk = ~pclk;
    sru_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sru_apb_master u_bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ------------------------------
    // checking and closing
    // ------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard, far above the few thousand cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    // expected {v, z, n, c, result}; multi-left v taken as 0
    function automatic logic [23:0] ref_op(input logic [2:0] op, input logic [1:0] sz,
        input logic [2:0] n, input logic [19:0] x, input logic c);
        int w;
        logic [19:0] m;
        logic v;
        logic b;
        w = (sz == 2'h0) ? 8 : (sz == 2'h1) ? 16 : 20;
        m = 20'hFFFFF >> (20 - w);
        x = x & m;
        v = (op == 3'h1 || op == 3'h2) ? x[w-1] ^ x[w-2] : 1'b0;
        for (int i = 0; i < n; i++) begin
            b = (op < 3'h3) ? x[w-1] : x[0];
            case (op)
                3'h0, 3'h1: x = (x << 1) & m;
                3'h2: x = ((x << 1) | 20'(c)) & m;
                3'h3, 3'h4: x = (x >> 1) | (x & (20'h1 << (w - 1)));
                default: x = (x >> 1) | (20'(c) << (w - 1));
            endcase
            c = b;
        end
        return {v, x == 20'h0, x[w-1], c, x};
    endfunction
    initial begin : main
        logic [23:0] e;
        logic [19:0] x;
        logic s;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        u_bus.xfer(1'b0, SRU_OFF_CTRL, 32'h0, rv, re);
        cmp(rv, 32'h00000110);
        u_bus.xfer(1'b0, 8'h20, 32'h0, rv, re);
        cmp({rv[30:0], re}, 32'h00000001);
        u_bus.xfer(1'b1, SRU_OFF_CTRL, 32'h80000003, rv, re);
        u_bus.xfer(1'b0, SRU_OFF_STATUS, 32'h0, rv, re);
        cmp(rv & 32'h00020000, 32'h00020000);
        // every op with its legal sizes and counts, two operands and both carries; single ops use carry as memory dest
        for (int op = 0; op < 7; op++)
            for (int sz = 0; sz < 3; sz++)
                for (int n = 1; n < 5; n++)
                    for (int p = 0; p < 4; p++) begin
                        s = !(op inside {0, 3, 5});
                        if ((s && n > 1) || (!s && sz == 0)) continue;
                        x = p[1] ? 20'h00001 : 20'h4C3A5;
                        u_bus.xfer(1'b1, SRU_OFF_STATUS, {31'h14, p[0]}, rv, re);
                        u_bus.xfer(1'b1, SRU_OFF_OPERAND, {12'h0, x}, rv, re);
                        u_bus.xfer(1'b1, SRU_OFF_CTRL, {1'b1, 18'h0, s & p[0], 1'b0,
                            n[2:0], 2'b0, sz[1:0], 1'b0, op[2:0]}, rv, re);
                        e = ref_op(op[2:0], sz[1:0], (s ? 3'h1 : n[2:0]), x, p[0]);
                        u_bus.xfer(1'b0, SRU_OFF_RESULT, 32'h0, rv, re);
                        cmp(rv, {12'h0, e[19:0]});
                        u_bus.xfer(1'b0, SRU_OFF_STATUS, 32'h0, rv, re);
                        cmp(rv, {23'h0, e[23], 5'h05, e[21], e[22], e[20]});
                        u_bus.xfer(1'b0, SRU_OFF_MEMMASK, 32'h0, rv, re);
                        cmp(rv, (s && p[0]) ? {29'h0, (sz == 0) ? SRU_LANES_BYTE :
                            (sz == 1) ? SRU_LANES_WORD : SRU_LANES_ADDR} : 32'h0);
                    end
        test_done();
    end
endmodule
`default_nettype wire
